// file: cis_sequencer.sv
// Purpose: Interrupt sequencer of the 8-bit core: flags, enables, redirection and return.
// Assumes: Core gives a one-clock tick in the last clock of each instruction cycle and marks its last cycle.
// Notes:   Pin events cross in through two flip-flops and cost up to one extra instruction cycle.
`timescale 1ns/1ps
`include "cis_defines.svh"
module cis_sequencer (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  // Register port
  input  cis_pkg::cis_bus_s           i_bus,
  output logic      [7:0]             o_rdata,
  // Event sources
  input  wire logic                   i_tmr_evt,
  input  wire logic                   i_ext_pin,
  input  wire logic                   i_chg_pin,
  input  wire logic [`CIS_NPER-1:0]   i_periph_evt,
  // Core handshake
  input  wire logic                   i_icyc_tick,
  input  wire logic                   i_insn_last,
  input  wire logic                   i_return_from_irq_op,
  input  wire logic [`CIS_PCW-1:0]    i_program_counter,
  input  cis_pkg::cis_ctx_s           i_core_ctx,
  output logic                        o_flush,
  output logic                        o_force_nop,
  output logic                        o_push,
  output logic      [`CIS_PCW-1:0]    o_push_pc,
  output logic                        o_pop,
  output logic                        o_load_vec,
  output logic      [`CIS_PCW-1:0]    o_vec_pc,
  output logic                        o_ctx_restore,
  output cis_pkg::cis_ctx_s           o_ctx,
  output logic                        o_irq
);
  import cis_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                      global_irq_enable_r;
  logic                      periph_group_irq_enable_r;
  logic [`CIS_NCORE-1:0]     core_en_r;
  logic [7:0]                periph_enable_reg_a_r;
  logic [7:0]                periph_enable_reg_b_r;
  logic [1:0]                pin_s1_r;
  logic [1:0]                pin_s2_r;
  logic [1:0]                pin_s3_r;
  logic [`CIS_NFLAG-1:0]     flag_set;
  logic [`CIS_NFLAG-1:0]     flag_clr;
  logic [`CIS_NFLAG-1:0]     flags;
  logic [`CIS_NCORE-1:0]     core_flags;
  logic [`CIS_NPER-1:0]      per_flags;
  logic                      core_pend;
  logic                      per_pend;
  logic                      take;
  logic                      accept;
  cis_state_e                state_r;
  cis_state_e                state_nxt;
  logic [1:0]                nop_cnt_r;
  logic                      shd_wr;
  logic [7:0]                shd_rbyte;
  logic [7:0]                rdata_nxt;

  // Address decode shared by the write and read paths
  function automatic logic hit(input logic [`CIS_AW-1:0] a, input logic [`CIS_AW-1:0] r);
    hit = (a == r);
  endfunction

  function automatic logic in_shadow(input logic [`CIS_AW-1:0] a);
    in_shadow = (a >= `CIS_ADDR_SHD_LO) && (a <= `CIS_ADDR_SHD_HI);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  // Third stage only feeds the edge detect, first stage only the second
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
    end else begin
      pin_s1_r <= {i_ext_pin, i_chg_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ---------------------------------------------------------------
  // Flags: order is {peripheral b, peripheral a, timer, ext pin, change pin}
  // ---------------------------------------------------------------
  // Events set flags regardless of any enable
  assign flag_set = {i_periph_evt, i_tmr_evt, pin_s2_r & ~pin_s3_r};
  // Write one to clear, per register
  always_comb begin
    flag_clr = '0;
    if (i_bus.wr && hit(i_bus.addr, `CIS_ADDR_CTRL)) begin
      flag_clr[`CIS_NCORE-1:0] = i_bus.wdata[`CIS_CFLG_HI:`CIS_CFLG_LO];
    end
    if (i_bus.wr && hit(i_bus.addr, `CIS_ADDR_PFLAG_A)) begin
      flag_clr[`CIS_NCORE +: 8] = i_bus.wdata;
    end
    if (i_bus.wr && hit(i_bus.addr, `CIS_ADDR_PFLAG_B)) begin
      flag_clr[`CIS_NCORE+8 +: 8] = i_bus.wdata;
    end
  end

  cis_flag_bank #(
    .WIDTH (`CIS_NFLAG)
  ) u_flags (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (flag_set),
    .i_clr     (flag_clr),
    .o_flag    (flags)
  );

  assign core_flags = flags[`CIS_NCORE-1:0];
  assign per_flags  = flags[`CIS_NFLAG-1:`CIS_NCORE];

  // ---------------------------------------------------------------
  // Enable gating
  // ---------------------------------------------------------------
  // Peripheral sources need the group enable on top of their own
  assign core_pend = |(core_flags & core_en_r);
  assign per_pend  = periph_group_irq_enable_r &
                     (|(per_flags & {periph_enable_reg_b_r, periph_enable_reg_a_r}));
  assign take      = global_irq_enable_r & (core_pend | per_pend);
  // Taken only at an instruction boundary so multi-cycle ops finish first
  assign accept    = (state_r == ST_IDLE) & i_icyc_tick & i_insn_last & take;
  assign o_irq     = core_pend | per_pend;

  // ---------------------------------------------------------------
  // Global enable
  // ---------------------------------------------------------------
  // Entry clear beats return set, which beats a software write
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      global_irq_enable_r <= 1'b0;
    end else if (accept) begin
      global_irq_enable_r <= 1'b0;
    end else if (i_return_from_irq_op) begin
      global_irq_enable_r <= 1'b1;
    end else if (i_bus.wr && hit(i_bus.addr, `CIS_ADDR_CTRL)) begin
      global_irq_enable_r <= i_bus.wdata[`CIS_BIT_GIE];
    end
  end

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  // Software-owned enables; all clear at reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      periph_group_irq_enable_r <= 1'b0;
      core_en_r                 <= '0;
      periph_enable_reg_a_r     <= `CIS_RST_BYTE;
      periph_enable_reg_b_r     <= `CIS_RST_BYTE;
    end else if (i_bus.wr) begin
      if (hit(i_bus.addr, `CIS_ADDR_CTRL)) begin
        periph_group_irq_enable_r <= i_bus.wdata[`CIS_BIT_PERIPH_GROUP_IRQ_ENABLE];
        core_en_r                 <= i_bus.wdata[`CIS_CEN_HI:`CIS_CEN_LO];
      end
      if (hit(i_bus.addr, `CIS_ADDR_PEN_A)) begin
        periph_enable_reg_a_r <= i_bus.wdata;
      end
      if (hit(i_bus.addr, `CIS_ADDR_PEN_B)) begin
        periph_enable_reg_b_r <= i_bus.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Redirection sequence
  // ---------------------------------------------------------------
  // Accept cycle, two forced no-op cycles, then the vector fetch
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        state_nxt = ST_NOP;
      end
      ST_NOP: begin
        // Leave on the second no-op tick so the vector load follows the two no-op cycles
        if (i_icyc_tick && ((nop_cnt_r + 2'h1) == `CIS_NOP_TICKS)) begin
          state_nxt = ST_VEC;
        end
      end
      ST_VEC: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counts instruction-cycle ticks spent as no-ops
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      nop_cnt_r <= 2'h0;
    end else if (state_r == ST_FLUSH) begin
      nop_cnt_r <= 2'h0;
    end else if ((state_r == ST_NOP) && i_icyc_tick) begin
      nop_cnt_r <= nop_cnt_r + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Core-facing strobes
  // ---------------------------------------------------------------
  // Save lands at the accept edge; flush and push follow one clock later
  assign o_flush       = (state_r == ST_FLUSH);
  assign o_push        = (state_r == ST_FLUSH);
  assign o_force_nop   = (state_r == ST_FLUSH) | (state_r == ST_NOP);
  assign o_load_vec    = (state_r == ST_VEC);
  assign o_pop         = i_return_from_irq_op;
  assign o_ctx_restore = i_return_from_irq_op;

  // Data outputs held in flip-flops
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_push_pc <= '0;
      o_vec_pc  <= '0;
    end else begin
      if (accept) begin
        o_push_pc <= i_program_counter;
      end
      o_vec_pc <= `CIS_VECTOR;
    end
  end

  // ---------------------------------------------------------------
  // Shadow context
  // ---------------------------------------------------------------
  assign shd_wr = i_bus.wr && in_shadow(i_bus.addr);

  cis_ctx_shadow u_shadow (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_save    (accept),
    .i_live    (i_core_ctx),
    .i_wr      (shd_wr),
    .i_idx     (3'(i_bus.addr - `CIS_ADDR_SHD_LO)),
    .i_wdata   (i_bus.wdata),
    .o_rbyte   (shd_rbyte),
    .o_restore (o_ctx)
  );

  // ---------------------------------------------------------------
  // Read path: data one cycle after the strobe, zero elsewhere
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(i_bus.addr, `CIS_ADDR_CTRL)) begin
      rdata_nxt = {global_irq_enable_r, periph_group_irq_enable_r, core_en_r, core_flags};
    end else if (hit(i_bus.addr, `CIS_ADDR_PFLAG_A)) begin
      rdata_nxt = per_flags[7:0];
    end else if (hit(i_bus.addr, `CIS_ADDR_PFLAG_B)) begin
      rdata_nxt = per_flags[15:8];
    end else if (hit(i_bus.addr, `CIS_ADDR_PEN_A)) begin
      rdata_nxt = periph_enable_reg_a_r;
    end else if (hit(i_bus.addr, `CIS_ADDR_PEN_B)) begin
      rdata_nxt = periph_enable_reg_b_r;
    end else if (in_shadow(i_bus.addr)) begin
      rdata_nxt = shd_rbyte;
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Helper: instruction-cycle ticks from the accept to the vector load
  logic [2:0] tick_cnt_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 3'h0;
    end else if (accept) begin
      tick_cnt_r <= 3'h1;
    end else if ((state_r != ST_IDLE) && i_icyc_tick) begin
      tick_cnt_r <= tick_cnt_r + 3'h1;
    end
  end

  reset_gie_a: assert property (@(posedge i_sys_clk) $rose(i_rst_n) |-> !global_irq_enable_r)
    else $error("global enable not clear after reset");
  need_enable_a: assert property (accept |-> global_irq_enable_r && (core_pend || per_pend))
    else $error("redirect without enables");
  group_gate_a: assert property (accept && !core_pend |-> periph_group_irq_enable_r)
    else $error("peripheral redirect without group enable");
  flag_set_a: assert property (i_tmr_evt |=> core_flags[`CIS_CFLG_HI])
    else $error("timer event did not set its flag");
  entry_seq_a: assert property (accept |=> o_flush && o_push && !global_irq_enable_r
                                && o_push_pc == $past(i_program_counter))
    else $error("entry sequence incomplete");
  gie_block_a: assert property (!global_irq_enable_r |=> state_r != ST_FLUSH)
    else $error("redirect while global enable clear");
  return_a: assert property (i_return_from_irq_op && !accept |-> o_pop && o_ctx_restore
                             ##1 global_irq_enable_r)
    else $error("return did not restore and re-enable");
  resume_a: assert property (state_r == ST_IDLE && take && i_icyc_tick && i_insn_last
                             |=> o_force_nop)
    else $error("pending interrupt not taken");
  pin_sync_a: assert property ($rose(i_chg_pin) |-> ##3 core_flags[`CIS_CFLG_LO])
    else $error("pin edge did not set its flag in time");
  vec_time_a: assert property (o_load_vec |-> tick_cnt_r == 3'h3 && o_vec_pc == `CIS_VECTOR)
    else $error("vector load at wrong instruction cycle");
  status_keep_a: assert property (((o_ctx.status ^ i_core_ctx.status) & `CIS_STAT_KEEP) == 8'h00)
    else $error("timeout or powerdown bits restored from shadow");

  accept_c: cover property (accept ##[1:20] o_load_vec);
  return_c: cover property (o_load_vec ##[1:50] i_return_from_irq_op);
  held_c:   cover property (!global_irq_enable_r && o_irq ##[1:20] accept);

endmodule

// file: cis_defines.svh
// Purpose: Constants of the interrupt sequencer: register map, field positions, reset values, vector.
// Assumes: One system clock; the core marks each instruction cycle with a one-clock tick.
// Notes:   Included by bare name; definitions only.
//
// Overview of operation
// - Reset leaves the global enable clear so no redirection can happen until software sets it.
// - A source redirects only while the global enable and its own enable are both set.
// - Sources enabled from the two peripheral enable registers also need the peripheral-group enable.
// - Every event sets its flag whatever the state of any enable bit.
// - Accepting an interrupt flushes the prefetch, clears the global enable, pushes the PC, loads 0004h.
// - Accepting an interrupt copies the core context into the shadow registers.
// - With the global enable clear an event still sets its flag but causes no redirection.
// - The return-from-interrupt op pops the PC, restores the shadow context and sets the global enable.
// - A flagged, enabled event held off by a clear global enable is taken as soon as it is set again.
// - A synchronous source reaches the vector three or four instruction cycles after its event.
// - An asynchronous source reaches the vector three to five instruction cycles after its event.
// - The shadow copy holds W, status minus timeout and powerdown bits, bank select, file selects, PC latch.
// - Core-side edits to shadowed registers are lost on return; edits to the shadow copies survive.
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH

// ---------------------------------------------------------------
// Register map (word index on the plain register port)
// ---------------------------------------------------------------
`define CIS_AW            8
`define CIS_ADDR_CTRL     8'h00
`define CIS_ADDR_PFLAG_A  8'h01
`define CIS_ADDR_PFLAG_B  8'h02
`define CIS_ADDR_PEN_A    8'h03
`define CIS_ADDR_PEN_B    8'h04
`define CIS_ADDR_SHD_LO   8'h05
`define CIS_ADDR_SHD_HI   8'h0c

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CIS_BIT_GIE       7
`define CIS_BIT_PERIPH_GROUP_IRQ_ENABLE      6
`define CIS_CEN_HI        5
`define CIS_CEN_LO        3
`define CIS_CFLG_HI       2
`define CIS_CFLG_LO       0
`define CIS_NCORE         3
`define CIS_NPER          16
`define CIS_NFLAG         19
`define CIS_RST_BYTE      8'h00

// ---------------------------------------------------------------
// Core interface constants
// ---------------------------------------------------------------
`define CIS_PCW           15
`define CIS_VECTOR        15'h0004
`define CIS_STAT_KEEP     8'h18
`define CIS_NSHD          8
`define CIS_NOP_TICKS     2'h2

`endif

// file: cis_pkg.sv
// Purpose: Types shared by the interrupt sequencer modules.
// Assumes: cis_defines.svh gives the widths.
// Notes:   Context struct is ordered so byte 0 is W and byte 7 is the PC latch.
`include "cis_defines.svh"
package cis_pkg;

  // ---------------------------------------------------------------
  // Core context and register port
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  pc_latch_high;
    logic [15:0] file_select_reg1;
    logic [15:0] file_select_reg0;
    logic [7:0]  bank_select_reg;
    logic [7:0]  status;
    logic [7:0]  w;
  } cis_ctx_s;

  typedef struct packed {
    logic [`CIS_AW-1:0] addr;
    logic [7:0]         wdata;
    logic               wr;
    logic               rd;
  } cis_bus_s;

  // Redirection sequence, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FLUSH = 4'h2,
    ST_NOP   = 4'h4,
    ST_VEC   = 4'h8
  } cis_state_e;

endpackage

// file: cis_flag_bank.sv
// Purpose: Sticky event flags, set by hardware, cleared by writing ones.
// Assumes: Set and clear arrive on the system clock.
// Notes:   A set in the same cycle as its clear wins, so no event is lost.
`timescale 1ns/1ps
`include "cis_defines.svh"
module cis_flag_bank #(
  parameter int WIDTH = `CIS_NFLAG
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clr,
  output logic      [WIDTH-1:0] o_flag
);
  import cis_pkg::*;

  // ---------------------------------------------------------------
  // One flip-flop per flag
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      // Set beats clear; flag holds until software clears it
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          o_flag[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_flag[g] <= 1'b1;
        end else if (i_clr[g]) begin
          o_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// file: cis_ctx_shadow.sv
// Purpose: Shadow copy of the core context, saved on entry and restored on return.
// Assumes: Save pulse comes from the sequencer; software may rewrite any shadow byte.
// Notes:   Timeout and powerdown status bits always come from the live status.
`timescale 1ns/1ps
`include "cis_defines.svh"
module cis_ctx_shadow (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_save,
  input  cis_pkg::cis_ctx_s     i_live,
  input  wire logic             i_wr,
  input  wire logic [2:0]       i_idx,
  input  wire logic [7:0]       i_wdata,
  output logic      [7:0]       o_rbyte,
  output cis_pkg::cis_ctx_s     o_restore
);
  import cis_pkg::*;

  logic [7:0] shd_r [`CIS_NSHD];
  logic [`CIS_NSHD*8-1:0] live_flat;
  logic [`CIS_NSHD*8-1:0] shd_flat;

  assign live_flat = i_live;

  // ---------------------------------------------------------------
  // Shadow bytes
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CIS_NSHD; g++) begin : g_shd
      // Hardware save wins over a software write in the same cycle
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          shd_r[g] <= `CIS_RST_BYTE;
        end else if (i_save) begin
          shd_r[g] <= live_flat[g*8 +: 8];
        end else if (i_wr && (i_idx == 3'(g))) begin
          shd_r[g] <= i_wdata;
        end
      end
      assign shd_flat[g*8 +: 8] = shd_r[g];
    end
  endgenerate

  // Restore value; timeout and powerdown are never rolled back
  always_comb begin
    o_restore        = shd_flat;
    o_restore.status = (shd_r[1] & ~`CIS_STAT_KEEP) | (i_live.status & `CIS_STAT_KEEP);
  end

  assign o_rbyte = shd_r[i_idx];

endmodule

// file: cis_core_model.sv
// Purpose: Behavioural core model: instruction-cycle ticks, program counter, live context.
// Assumes: Every instruction is single-cycle, so each tick ends one.
// Notes:   The stack is not modelled; the bench checks the pushed value itself.
`timescale 1ns/1ps
module cis_core_model (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load_vec,
  input  wire logic  [14:0] i_vec_pc,
  output logic              o_tick,
  output logic              o_last,
  output logic       [14:0] o_pc,
  output cis_pkg::cis_ctx_s o_ctx
);
  import cis_pkg::*;
  logic [1:0] phase_r;
  // Four clocks per instruction cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) phase_r <= 2'h0;
    else phase_r <= phase_r + 2'h1;
  end
  assign o_tick = (phase_r == 2'h3);
  assign o_last = 1'b1;
  // Jump when the vector is loaded, else step once per tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) o_pc <= 15'h0100;
    else if (i_load_vec) o_pc <= i_vec_pc;
    else if (o_tick) o_pc <= o_pc + 15'h0001;
  end
  // Fixed context so every shadow byte is distinct
  assign o_ctx = 64'h0123_4567_89ab_cdef;
endmodule

// file: tb_cis_sequencer.sv
// Purpose: Self-checking bench of the interrupt sequencer.
// Assumes: The core model ticks every fourth clock.
// Notes:   Every wait is bounded; a timeout counts as a mismatch.
`timescale 1ns/1ps
module tb_cis_sequencer;
  import cis_pkg::*;
  logic        i_sys_clk, i_rst_n, i_tmr_evt, i_ext_pin, i_chg_pin, i_ret, tick, last;
  logic        o_flush, o_force_nop, o_push, o_pop, o_load_vec, o_ctx_restore, o_irq;
  logic [15:0] i_periph_evt;
  logic [14:0] pc, o_push_pc, o_vec_pc;
  logic [7:0]  o_rdata, d;
  cis_bus_s    bus;
  cis_ctx_s    ctx, o_ctx;
  int          miscompares, checked, n;
  cis_core_model u_core (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_load_vec(o_load_vec), .i_vec_pc(o_vec_pc),
    .o_tick(tick), .o_last(last), .o_pc(pc), .o_ctx(ctx));
  cis_sequencer u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(o_rdata), .i_tmr_evt(i_tmr_evt),
    .i_ext_pin(i_ext_pin), .i_chg_pin(i_chg_pin), .i_periph_evt(i_periph_evt), .i_icyc_tick(tick), .i_insn_last(last),
    .i_return_from_irq_op(i_ret), .i_program_counter(pc), .i_core_ctx(ctx), .o_flush(o_flush),
    .o_force_nop(o_force_nop), .o_push(o_push), .o_push_pc(o_push_pc), .o_pop(o_pop), .o_load_vec(o_load_vec),
    .o_vec_pc(o_vec_pc), .o_ctx_restore(o_ctx_restore), .o_ctx(o_ctx), .o_irq(o_irq));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk) bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk) bus <= '0;
    #1 v = o_rdata;
  endtask
  // Wait for flush (sel 0) or vector load (sel 1), counting clocks
  task automatic wt(input bit sel, output int k);
    for (k = 1; k <= 40; k++) begin
      @(posedge i_sys_clk) #1;
      if ((sel ? o_load_vec : o_flush) === 1'b1) return;
    end
    miscompares++;
    end_of_test();
  endtask
  task automatic quiet();
    repeat (12) begin
      @(posedge i_sys_clk) #1;
      chk(o_flush, 1'b0);
    end
  endtask
  // Free-running system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    bus = '0;
    {i_tmr_evt, i_ext_pin, i_chg_pin, i_ret} = 4'h0;
    i_periph_evt = 16'h0000;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(8'h00, d);
    chk(d, 8'h00);
    @(posedge i_sys_clk) {i_tmr_evt, i_ext_pin, i_chg_pin} <= 3'h7;
    @(posedge i_sys_clk) i_tmr_evt <= 1'b0;
    wr(8'h00, 8'h20);
    quiet();
    rd(8'h00, d);
    chk(d, 8'h27);
    // Clearing two flags and raising the global enable takes the held event
    wr(8'h00, 8'ha3);
    wt(1'b0, n);
    chk({o_push, o_force_nop, o_push_pc}, {2'h3, pc - 15'h0001});
    wt(1'b1, n);
    chk({n, o_vec_pc}, {32'd8, 15'h0004});
    rd(8'h00, d);
    chk(d, 8'h24);
    rd(8'h05, d);
    chk(d, 8'hef);
    wr(8'h05, 8'h5a);
    wr(8'h00, 8'h24);
    @(posedge i_sys_clk) i_ret <= 1'b1;
    #1 chk({o_pop, o_ctx_restore}, 2'h3);
    chk(o_ctx, 64'h0123_4567_89ab_cd5a);
    @(posedge i_sys_clk) i_ret <= 1'b0;
    rd(8'h00, d);
    chk(d, 8'ha0);
    // Peripheral source waits for the group enable
    wr(8'h03, 8'h01);
    @(posedge i_sys_clk) i_periph_evt <= 16'h0001;
    @(posedge i_sys_clk) i_periph_evt <= 16'h0000;
    quiet();
    chk(o_irq, 1'b0);
    wr(8'h00, 8'he0);
    wt(1'b0, n);
    chk(o_irq, 1'b1);
    rd(8'h01, d);
    chk(d, 8'h01);
    wr(8'h01, 8'h01);
    #1 chk(o_irq, 1'b0);
    end_of_test();
  end
endmodule
